// ===== bst_tap.sv
/*
 Test access port, instruction decode, bypass, identification and
 boundary scan register with pin muxing. Assumes the test clock is
 far slower than i_clk; test pins are sampled by i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.svh"
// Behaviour
// - Test pins plus async active-low port reset
// - Port reset selects identification path
// - Update loads shifted code, else identification
// - Unknown codes act as bypass
// - Bypass code gives one-stage path
// - Clamp: bypass path, pins held from cells
// - External test: pins driven from cells
// - High-z: all outputs off, bypass path
// - Sample: snapshot pins, normal operation kept
// - Identification fields version, family, maker
// - User view: other version, part number
// - Scan register 161 cells, three per bidir
module bst_tap #(
  parameter int          N_IN      = `BST_N_IN,
  parameter int          N_OUT     = `BST_N_OUT,
  parameter int          N_BIDIR   = `BST_N_BIDIR,
  // Identity values are arbitrary
  parameter logic [3:0]  ID_VER    = 4'h3,
  parameter logic [3:0]  USER_VER  = 4'h4,
  parameter logic [15:0] FAMILY    = 16'h1234,
  parameter logic [15:0] PART_NUM  = 16'h1234,
  parameter logic [10:0] MAKER     = 11'h2a5
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  // Test port
  input  wire logic               i_tck,
  input  wire logic               i_tms,
  input  wire logic               i_tdi,
  input  wire logic               i_trstn,
  output logic                    o_tdo,
  output logic                    o_tdo_oe_n,
  // Pins
  input  wire logic [N_IN-1:0]    i_pin_in,
  output logic      [N_OUT-1:0]   o_pin_out,
  output logic      [N_OUT-1:0]   o_pin_oe_n,
  input  wire logic [N_BIDIR-1:0] i_bidir_in,
  output logic      [N_BIDIR-1:0] o_bidir_out,
  output logic      [N_BIDIR-1:0] o_bidir_oe_n,
  // Core side
  output logic      [N_IN-1:0]    o_core_in,
  input  wire logic [N_OUT-1:0]   i_core_out,
  output logic      [N_BIDIR-1:0] o_core_bidir_in,
  input  wire logic [N_BIDIR-1:0] i_core_bidir_out,
  input  wire logic [N_BIDIR-1:0] i_core_bidir_oe_n
);
  import bst_pkg::*;

  localparam int BSR_LEN = N_IN + N_OUT + 3 * N_BIDIR;
  localparam int O_LO = N_IN;
  localparam int BI_LO = O_LO + N_OUT;
  localparam int BO_LO = BI_LO + N_BIDIR;
  localparam int BC_LO = BO_LO + N_BIDIR;
  localparam int SW = 3 + N_IN + N_BIDIR;
  localparam logic [`BST_ID_W-1:0] IDCODE = {ID_VER, FAMILY, MAKER, `BST_ONE};
  localparam logic [`BST_ID_W-1:0] USERCODE = {USER_VER, PART_NUM, MAKER, `BST_ONE};

  // ******************************
  // Pin sampling and edges
  // ******************************
  logic [SW-1:0]        sync_q;
  logic                 tck_s;
  logic                 tms_s;
  logic                 tdi_s;
  logic [N_IN-1:0]      pin_in_s;
  logic [N_BIDIR-1:0]   bidir_in_s;
  logic                 tck_prev;
  logic                 tck_rise;
  logic                 tck_fall;
  logic                 tap_rst_n;

  bst_sync #(.W(SW)) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      ({i_tck, i_tms, i_tdi, i_pin_in, i_bidir_in}),
    .o_q      (sync_q)
  );

  assign {tck_s, tms_s, tdi_s, pin_in_s, bidir_in_s} = sync_q;
  assign tck_rise = tck_s & ~tck_prev;
  assign tck_fall = ~tck_s & tck_prev;
  assign tap_rst_n = i_resetn & i_trstn;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      tck_prev <= `BST_ZERO;
    else
      tck_prev <= tck_s;
  end

  // ******************************
  // Controller
  // ******************************
  bst_state_e state;
  bst_state_e next_state;

  function automatic bst_state_e step(input bst_state_e s, input logic m);
    case (s)
      BST_TLR:    step = m ? BST_TLR    : BST_IDLE;
      BST_IDLE:   step = m ? BST_SEL_DR : BST_IDLE;
      BST_SEL_DR: step = m ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: step = m ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR:  step = m ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: step = m ? BST_UP_DR  : BST_PA_DR;
      BST_PA_DR:  step = m ? BST_EX2_DR : BST_PA_DR;
      BST_EX2_DR: step = m ? BST_UP_DR  : BST_SH_DR;
      BST_UP_DR:  step = m ? BST_SEL_DR : BST_IDLE;
      BST_SEL_IR: step = m ? BST_TLR    : BST_CAP_IR;
      BST_CAP_IR: step = m ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR:  step = m ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: step = m ? BST_UP_IR  : BST_PA_IR;
      BST_PA_IR:  step = m ? BST_EX2_IR : BST_PA_IR;
      BST_EX2_IR: step = m ? BST_UP_IR  : BST_SH_IR;
      BST_UP_IR:  step = m ? BST_SEL_DR : BST_IDLE;
      default:    step = BST_TLR;
    endcase
  endfunction

  always_comb
  begin
    next_state = state;
    if (tck_rise)
      next_state = step(state, tms_s);
  end

  always_ff @(posedge i_clk or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      state <= BST_TLR;
    else
      state <= next_state;
  end

  // ******************************
  // Instruction register
  // ******************************
  logic [`BST_IR_W-1:0] ir;
  logic [`BST_IR_W-1:0] ir_sh;
  logic                 ir_new;

  always_ff @(posedge i_clk or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      ir     <= `BST_IR_IDCODE;
      ir_sh  <= `BST_IR_CAPTURE;
      ir_new <= `BST_ZERO;
    end
    else if (tck_rise)
    begin
      case (state)
        BST_TLR:
        begin
          ir     <= `BST_IR_IDCODE;
          ir_new <= `BST_ZERO;
        end
        BST_CAP_IR: ir_sh <= `BST_IR_CAPTURE;
        BST_SH_IR:
        begin
          ir_sh  <= {tdi_s, ir_sh[`BST_IR_W-1:1]};
          ir_new <= `BST_ONE;
        end
        BST_UP_IR:
        begin
          ir     <= ir_new ? ir_sh : `BST_IR_IDCODE;
          ir_new <= `BST_ZERO;
        end
        default: ir_new <= ir_new;
      endcase
    end
  end

  // ******************************
  // Decode
  // ******************************
  bst_path_e path;
  logic      drive_bsr;
  logic      highz;

  always_comb
  begin
    case (ir)
      `BST_IR_EXTEST, `BST_IR_SAMPLE: path = BST_PATH_BSR;
      `BST_IR_IDCODE, `BST_IR_USER:   path = BST_PATH_ID;
      default:                        path = BST_PATH_BYP;
    endcase
  end

  assign drive_bsr = (ir == `BST_IR_EXTEST) || (ir == `BST_IR_CLAMP);
  assign highz = (ir == `BST_IR_HIGHZ);

  // ******************************
  // Data registers
  // ******************************
  logic                  byp;
  logic [`BST_ID_W-1:0]  id_sh;
  logic [BSR_LEN-1:0]    bsr_sh;
  logic [BSR_LEN-1:0]    bsr_upd;
  logic [N_OUT-1:0]      next_pin_out;
  logic [N_OUT-1:0]      next_pin_oe_n;
  logic [N_BIDIR-1:0]    next_bidir_out;
  logic [N_BIDIR-1:0]    next_bidir_oe_n;

  always_ff @(posedge i_clk or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      byp     <= `BST_ZERO;
      id_sh   <= '0;
      bsr_sh  <= '0;
      bsr_upd <= '0;
    end
    else if (tck_rise)
    begin
      case (state)
        BST_CAP_DR:
        begin
          byp    <= `BST_ZERO;
          id_sh  <= (ir == `BST_IR_USER) ? USERCODE : IDCODE;
          bsr_sh <= {next_bidir_oe_n, next_bidir_out, bidir_in_s,
                     next_pin_out, pin_in_s};
        end
        BST_SH_DR:
        begin
          case (path)
            BST_PATH_BSR: bsr_sh <= {tdi_s, bsr_sh[BSR_LEN-1:1]};
            BST_PATH_ID:  id_sh <= {tdi_s, id_sh[`BST_ID_W-1:1]};
            default:      byp <= tdi_s;
          endcase
        end
        BST_UP_DR:
        begin
          if (path == BST_PATH_BSR)
            bsr_upd <= bsr_sh;
        end
        default: byp <= byp;
      endcase
    end
  end

  // ******************************
  // Pin muxing
  // ******************************
  always_comb
  begin
    next_pin_out    = i_core_out;
    next_pin_oe_n   = '0;
    next_bidir_out  = i_core_bidir_out;
    next_bidir_oe_n = i_core_bidir_oe_n;
    if (highz)
    begin
      next_pin_oe_n   = '1;
      next_bidir_oe_n = '1;
    end
    else if (drive_bsr)
    begin
      next_pin_out    = bsr_upd[BI_LO-1:O_LO];
      next_bidir_out  = bsr_upd[BC_LO-1:BO_LO];
      next_bidir_oe_n = bsr_upd[BSR_LEN-1:BC_LO];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_pin_out       <= '0;
      o_pin_oe_n      <= '1;
      o_bidir_out     <= '0;
      o_bidir_oe_n    <= '1;
      o_core_in       <= '0;
      o_core_bidir_in <= '0;
    end
    else
    begin
      o_pin_out       <= next_pin_out;
      o_pin_oe_n      <= next_pin_oe_n;
      o_bidir_out     <= next_bidir_out;
      o_bidir_oe_n    <= next_bidir_oe_n;
      o_core_in       <= pin_in_s;
      o_core_bidir_in <= bidir_in_s;
    end
  end

  // ******************************
  // Serial output
  // ******************************
  logic tdo_bit;

  always_comb
  begin
    case (path)
      BST_PATH_BSR: tdo_bit = bsr_sh[0];
      BST_PATH_ID:  tdo_bit = id_sh[0];
      default:      tdo_bit = byp;
    endcase
    if (state == BST_SH_IR)
      tdo_bit = ir_sh[0];
  end

  always_ff @(posedge i_clk or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      o_tdo      <= `BST_ZERO;
      o_tdo_oe_n <= `BST_ONE;
    end
    else if (tck_fall)
    begin
      o_tdo      <= tdo_bit;
      o_tdo_oe_n <= !((state == BST_SH_DR) || (state == BST_SH_IR));
    end
  end

  // ******************************
  // Assertions
  // ******************************
  trst_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_trstn |-> state == BST_TLR) else $error("port reset missed");
  tlr_idcode_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    (state == BST_TLR && tck_rise) |=> ir == `BST_IR_IDCODE && path == BST_PATH_ID)
    else $error("reset path not identification");
  ir_default_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    (state == BST_UP_IR && tck_rise && !ir_new) |=> ir == `BST_IR_IDCODE)
    else $error("default code not loaded");
  ir_load_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    (state == BST_UP_IR && tck_rise && ir_new) |=> ir == $past(ir_sh))
    else $error("shifted code not loaded");
  ir_capture_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    (state == BST_CAP_IR && tck_rise) |=> ir_sh[1:0] == 2'h1)
    else $error("capture pattern wrong");
  unknown_byp_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    !(ir inside {`BST_IR_EXTEST, `BST_IR_SAMPLE, `BST_IR_IDCODE, `BST_IR_USER})
    |-> path == BST_PATH_BYP) else $error("unknown code not bypass");
  byp_stage_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    (state == BST_SH_DR && tck_rise && path == BST_PATH_BYP) |=> byp == $past(tdi_s))
    else $error("bypass stage wrong");
  clamp_hold_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    ($past(ir) == `BST_IR_CLAMP) |-> o_pin_out == $past(bsr_upd[BI_LO-1:O_LO]))
    else $error("clamp not holding");
  extest_drive_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    ($past(ir) == `BST_IR_EXTEST)
    |-> o_bidir_oe_n == $past(bsr_upd[BSR_LEN-1:BC_LO]) && $past(path) == BST_PATH_BSR)
    else $error("external test drive wrong");
  highz_off_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    ($past(ir) == `BST_IR_HIGHZ) |-> (&o_pin_oe_n) && (&o_bidir_oe_n))
    else $error("high-z not off");
  sample_core_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    ($past(ir) == `BST_IR_SAMPLE) |-> o_pin_out == $past(i_core_out))
    else $error("sample disturbed outputs");
  id_fields_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    (state == BST_CAP_DR && tck_rise && ir == `BST_IR_IDCODE)
    |=> id_sh[0] && id_sh[31:28] == ID_VER && id_sh[27:12] == FAMILY)
    else $error("identification wrong");
  user_view_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    (state == BST_CAP_DR && tck_rise && ir == `BST_IR_USER)
    |=> id_sh[31:28] == USER_VER && id_sh[27:12] == PART_NUM)
    else $error("user view wrong");
  bsr_shift_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    (state == BST_SH_DR && tck_rise && path == BST_PATH_BSR)
    |=> bsr_sh[BSR_LEN-1] == $past(tdi_s) && bsr_sh[BSR_LEN-2:0] == $past(bsr_sh[BSR_LEN-1:1]))
    else $error("scan shift wrong");
  tdo_off_a: assert property (@(posedge i_clk) disable iff (!tap_rst_n)
    (tck_fall && state != BST_SH_DR && state != BST_SH_IR) |=> o_tdo_oe_n)
    else $error("data out driven outside shift");

  ir_upd_c: cover property (@(posedge i_clk) disable iff (!tap_rst_n)
    state == BST_UP_IR && tck_rise && ir_new);
  extest_c: cover property (@(posedge i_clk) disable iff (!tap_rst_n)
    ir == `BST_IR_EXTEST && state == BST_UP_DR && tck_rise);
  id_read_c: cover property (@(posedge i_clk) disable iff (!tap_rst_n)
    path == BST_PATH_ID && state == BST_SH_DR && tck_fall);
  highz_c: cover property (@(posedge i_clk) disable iff (!tap_rst_n) highz);
endmodule
`default_nettype wire

// ===== bst_map.svh
/*
 Constant map of the boundary scan test port: instruction codes,
 register widths, capture pattern and pin counts.
 Assumes inclusion by bare name from the design.
*/
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

`define BST_IR_W       6
`define BST_IR_EXTEST  6'h00
`define BST_IR_SAMPLE  6'h01
`define BST_IR_CLAMP   6'h02
`define BST_IR_HIGHZ   6'h05
`define BST_IR_IDCODE  6'h20
`define BST_IR_USER    6'h25
`define BST_IR_BYPASS  6'h3f
`define BST_IR_CAPTURE 6'h01
`define BST_ID_W       32
`define BST_BSR_LEN    161
`define BST_N_IN       40
`define BST_N_OUT      40
`define BST_N_BIDIR    27
`define BST_ONE        1'h1
`define BST_ZERO       1'h0

`endif

// ===== bst_pkg.sv
/*
 Types of the boundary scan test port: controller states and the
 selected serial path. Assumes nothing of its surroundings.
*/
`default_nettype none
package bst_pkg;
  typedef enum logic [15:0] {
    BST_TLR    = 16'h0001,
    BST_IDLE   = 16'h0002,
    BST_SEL_DR = 16'h0004,
    BST_CAP_DR = 16'h0008,
    BST_SH_DR  = 16'h0010,
    BST_EX1_DR = 16'h0020,
    BST_PA_DR  = 16'h0040,
    BST_EX2_DR = 16'h0080,
    BST_UP_DR  = 16'h0100,
    BST_SEL_IR = 16'h0200,
    BST_CAP_IR = 16'h0400,
    BST_SH_IR  = 16'h0800,
    BST_EX1_IR = 16'h1000,
    BST_PA_IR  = 16'h2000,
    BST_EX2_IR = 16'h4000,
    BST_UP_IR  = 16'h8000
  } bst_state_e;

  typedef enum logic [2:0] {
    BST_PATH_BYP = 3'h1,
    BST_PATH_ID  = 3'h2,
    BST_PATH_BSR = 3'h4
  } bst_path_e;
endpackage
`default_nettype wire

// ===== bst_sync.sv
/*
 Two flip-flop synchroniser for a bus of independent levels.
 Assumes each bit is a level that stays for several clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module bst_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Levels
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta <= '0;
      o_q  <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== bst_tester.sv
/*
 Board tester model: makes the test clock, mode select and data in,
 collects data out. Assumes the bench pulls the data out wire up.
*/
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
  // Clock
  input  wire logic         i_clk,
  // Test port
  input  wire logic         i_tdo,
  output logic              o_tck,
  output logic              o_tms,
  output logic              o_tdi,
  // Result
  output logic              o_done,
  output logic [191:0]      o_word
);
  // ****************
  // Frame sequencing
  // ****************
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_done = 1'b0;
    o_word = '0;
  end

  // Lines move on the fall; data out taken just before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(negedge i_clk);
    tdo = i_tdo;
    o_tck = 1'b1;
    repeat (4) @(negedge i_clk);
    o_tck = 1'b0;
  endtask

  task automatic reset_tap();
    logic d;
    repeat (5) tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
  endtask

  // Idle to shift, n bits, update, back to idle; clock stops after
  task automatic scan(input logic ir, input int n, input logic [191:0] din);
    logic         d;
    logic [191:0] w;
    w = '0;
    tick(1'b1, 1'b0, d);
    if (ir)
      tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
    tick(n == 0, 1'b0, d);
    for (int i = 0; i < n; i++)
      tick(i == n - 1, din[i], w[i]);
    tick(1'b1, 1'b0, d);
    tick(1'b0, 1'b0, d);
    o_tdi = ~o_tdi;
    o_word = w;
    o_done = 1'b1;
    @(negedge i_clk);
    o_done = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== bst_tap_tb_top.sv
/*
 Self-checking bench of the boundary scan test port.
 Assumes the tap design and the tester model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module bst_tap_tb_top;
  // Identity values are arbitrary
  localparam logic [31:0] ID_W   = {4'h3, 16'h1234, 11'h2a5, 1'b1};
  localparam logic [31:0] USER_W = {4'h4, 16'h1234, 11'h2a5, 1'b1};
  logic         clk;
  logic         resetn;
  logic         trstn;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic         tdo;
  logic         tdo_oe_n;
  logic         tdo_wire;
  logic [39:0]  pin_out;
  logic [39:0]  pin_oe_n;
  logic [26:0]  bidir_out;
  logic [26:0]  bidir_oe_n;
  logic [26:0]  bidir_wire;
  logic [39:0]  core_in;
  logic [26:0]  core_bidir_in;
  logic [160:0] rv;
  logic [160:0] pre;
  logic [31:0]  seed;
  logic         done;
  logic         d_unused;
  logic [191:0] word;
  logic [191:0] expq[$];
  logic [5:0]   codes[4] = '{6'h3f, 6'h15, 6'h02, 6'h05};
  int           num_errors;
  int           n_tests;

  // Data out pulled up while released
  assign tdo_wire = tdo_oe_n ? 1'b1 : tdo;
  assign bidir_wire = (bidir_oe_n & rv[106:80]) | (~bidir_oe_n & bidir_out);

  initial
  begin
    clk = 1'b0;
  end
  always #20 clk = ~clk;

  bst_tap #(.ID_VER(ID_W[31:28]), .USER_VER(USER_W[31:28]), .FAMILY(ID_W[27:12]),
    .PART_NUM(USER_W[27:12]), .MAKER(ID_W[11:1])) dut (
    .i_clk(clk), .i_resetn(resetn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_trstn(trstn), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .i_pin_in(rv[39:0]),
    .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n), .i_bidir_in(bidir_wire),
    .o_bidir_out(bidir_out), .o_bidir_oe_n(bidir_oe_n), .o_core_in(core_in),
    .i_core_out(rv[79:40]), .o_core_bidir_in(core_bidir_in), .i_core_bidir_out(rv[133:107]),
    .i_core_bidir_oe_n(rv[160:134]));

  bst_tester tst (.i_clk(clk), .i_tdo(tdo_wire), .o_tck(tck), .o_tms(tms),
    .o_tdi(tdi), .o_done(done), .o_word(word));

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [26:0] bin_of(input logic [26:0] c, input logic [26:0] o,
                                         input logic [26:0] x);
    return (c & x) | (~c & o);
  endfunction

  task automatic roll();
    @(negedge clk);
    for (int i = 0; i < 161; i++)
    begin
      seed = lfsr(seed);
      rv[i] = seed[9];
    end
  endtask

  task automatic check(input logic [191:0] seen, input logic [191:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic frame(input logic ir, input int n, input logic [191:0] din,
                       input logic [191:0] exp);
    expq.push_back(exp);
    tst.scan(ir, n, din);
    repeat (6) @(negedge clk);
  endtask

  task automatic set_ir(input logic [5:0] code);
    frame(1'b1, 6, 192'(code), 192'h01);
  endtask

  task automatic byp();
    logic [191:0] d;
    seed = lfsr(seed);
    d = 192'(seed[7:0]);
    frame(1'b0, 8, d, {d[190:0], 1'b0} & 192'hff);
  endtask

  always @(posedge clk)
    if (done === 1'b1)
      check(word, expq.pop_front());

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    seed = 32'hcaab8728;
    rv = '0;
    resetn = 1'b0;
    trstn = 1'b1;
    num_errors = 0;
    n_tests = 0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    tst.reset_tap();
    frame(1'b0, 32, '0, 192'(ID_W));
    foreach (codes[i])
    begin
      set_ir(codes[i]);
      byp();
    end
    check(192'(pin_oe_n), 192'({40{1'b1}}));
    check(192'(bidir_oe_n), 192'({27{1'b1}}));
    check(192'(tdo_oe_n), 192'h1);
    set_ir(6'h25);
    frame(1'b0, 32, '0, 192'(USER_W));
    set_ir(6'h20);
    frame(1'b0, 32, '0, 192'(ID_W));
    set_ir(6'h25);
    frame(1'b1, 0, '0, '0);
    frame(1'b0, 32, '0, 192'(ID_W));
    roll();
    set_ir(6'h01);
    pre = {rv[80:0], rv[160:81]};
    frame(1'b0, 161, 192'(pre), 192'({rv[160:107],
      bin_of(rv[160:134], rv[133:107], rv[106:80]), rv[79:0]}));
    check(192'(pin_out), 192'(rv[79:40]));
    check(192'(core_in), 192'(rv[39:0]));
    check(192'(core_bidir_in), 192'(bin_of(rv[160:134], rv[133:107], rv[106:80])));
    set_ir(6'h00);
    check(192'(pin_out), 192'(pre[79:40]));
    check(192'(pin_oe_n), 192'h0);
    check(192'(bidir_out), 192'(pre[133:107]));
    check(192'(bidir_oe_n), 192'(pre[160:134]));
    roll();
    frame(1'b0, 162, 192'(pre), {30'h0, pre[0], pre[160:107],
      bin_of(pre[160:134], pre[133:107], rv[106:80]), pre[79:40], rv[39:0]});
    set_ir(6'h02);
    roll();
    repeat (4) @(negedge clk);
    check(192'(pin_out), 192'(pre[80:41]));
    trstn = 1'b0;
    repeat (2) @(negedge clk);
    trstn = 1'b1;
    repeat (6) @(negedge clk);
    check(192'(pin_out), 192'(rv[79:40]));
    tst.tick(1'b0, 1'b0, d_unused);
    frame(1'b0, 32, '0, 192'(ID_W));
    complete_run();
  end
endmodule
`default_nettype wire
